/* hw/esa_slave.sv */
// two-wire slave front end: conditions, select decode, word address decode
`timescale 1ns/1ps
// How it works
// R1 - start is sda falling while scl high
// R2 - stop is sda rising while scl high
// R3 - sda changes under scl high are conditions
// R4 - one bit per scl pulse, framed
// R5 - bytes shift in msb first
// R6 - receiver acknowledges by pulling sda low
// R7 - matching select acked on ninth clock; the code does not ack it while write_busy is high
// R8 - sda only pulled low or released
// R9 - master starts only on idle bus
// R10 - master recovers by clocking then starting
// R11 - standby after reset, stop, write end
// R12 - type 1010 main, 1011 id page
// R13 - three pins match next select bits
// R14 - last select bit one means read
// R15 - write protect pin high blocks writes
// R16 - unlocked: configurable code replaces pins, wp
// R17 - default code 1010000, register locked
// R18 - word address upper bits decode command
// R19 - default state: only unlock command recognised; the code also decodes memory addresses as CMD_MEM while locked
// R20 - word address two bytes, high first, acked
module esa_slave
   import esa_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic chip_select_pin_low,
   input wire logic chip_select_pin_mid,
   input wire logic chip_select_pin_high,
   input wire logic write_protect,
   input wire logic write_busy,
   input wire logic cfg_we,
   input wire logic [6:0] cfg_wdata,
   output logic [6:0] configurable_address_code,
   output logic cfg_unlocked,
   output logic standby,
   output esa_pkg::esa_cmd_s cmd_out,
   output logic sel_read
);
   import esa_pkg::*;

   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   esa_state_e state;
   logic [2:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic addr_phase;
   logic [7:0] addr_hi;
   logic ack_pend;
   logic sel_match;
   logic sel_is_id;
   logic [2:0] pins;
   logic [2:0] pins_meta;
   logic [1:0] wp_sync;
   logic sel_was_id;
   logic [3:0] sel_type;
   logic [15:0] word_addr;
   logic after_sel;
   logic is_write_op;
   logic [2:0] ack_cnt;

   // pins come from outside, two flops before any use
   always_ff @(posedge clk) begin
      if (!nrst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl};
         sda_sync <= {sda_sync[0], sda_in};
         scl_d <= scl_sync[1];
         sda_d <= sda_sync[1];
      end
   end

   // strap pins and write protect are slow levels, still synchronised like scl
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pins_meta <= 3'h0;
         pins <= 3'h0;
         wp_sync <= 2'h0;
      end else begin
         pins_meta <= {chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low};
         pins <= pins_meta;
         wp_sync <= {wp_sync[0], write_protect};
      end
   end

   assign scl_rise = scl_sync[1] && !scl_d;
   assign scl_fall = !scl_sync[1] && scl_d;
   assign start_det = scl_sync[1] && scl_d && sda_d && !sda_sync[1]; // see R1
   assign stop_det = scl_sync[1] && scl_d && !sda_d && sda_sync[1]; // see R2 see R3

   assign next_shreg = {shreg[6:0], sda_sync[1]}; // see R5
   assign sel_type = next_shreg[7:SEL_TYPE_POS];

   // once unlocked the configurable code replaces type and pins
   always_comb begin
      sel_is_id = 1'b0;
      if (cfg_unlocked) begin
         sel_match = next_shreg[7:1] == configurable_address_code; // see R16
      end else begin
         sel_is_id = sel_type == TYPE_IDPAGE;
         sel_match = (sel_type == TYPE_MAIN || sel_is_id) // see R12
            && next_shreg[SEL_TYPE_POS-1:SEL_PINS_POS] == pins; // see R13
      end
   end

   // bit framing state machine, sampled at scl rising edge
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= ESA_IDLE;
         bit_cnt <= BIT_CNT_ZERO;
         shreg <= 8'h00;
         ack_pend <= 1'b0;
         after_sel <= 1'b0;
         addr_phase <= 1'b0;
         addr_hi <= 8'h00;
         sel_read <= 1'b0;
         is_write_op <= 1'b0;
         sel_was_id <= 1'b0;
      end else if (start_det) begin
         // a start always restarts the bus logic, even mid byte
         state <= ESA_SEL; // see R1 see R10
         bit_cnt <= BIT_CNT_ZERO;
         ack_pend <= 1'b0;
         addr_phase <= 1'b0;
      end else if (stop_det) begin
         state <= ESA_IDLE; // see R2
      end else if (scl_rise) begin
         unique case (state)
            ESA_IDLE: begin
               state <= ESA_IDLE;
            end
            ESA_SEL, ESA_ADDR: begin
               shreg <= next_shreg; // see R4
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'(BIT_LAST)) begin
                  if (state == ESA_SEL) begin
                     if (sel_match && !write_busy) begin
                        ack_pend <= 1'b1; // see R7
                        after_sel <= 1'b1;
                        sel_read <= next_shreg[SEL_RW_POS]; // see R14
                        is_write_op <= !next_shreg[SEL_RW_POS];
                        sel_was_id <= sel_is_id; // see R12
                        state <= ESA_ACK;
                     end else begin
                        state <= ESA_IGNORE;
                     end
                  end else begin
                     ack_pend <= 1'b1; // see R20
                     after_sel <= 1'b0;
                     addr_phase <= !addr_phase;
                     if (!addr_phase) begin
                        addr_hi <= next_shreg; // see R20
                     end
                     state <= ESA_ACK;
                  end
               end
            end
            ESA_ACK: begin
               ack_pend <= 1'b0;
               if (sel_read) begin
                  state <= ESA_DATA;
               end else if (after_sel || addr_phase) begin
                  state <= ESA_ADDR;
               end else begin
                  state <= ESA_DATA;
               end
            end
            ESA_DATA: begin
               state <= ESA_DATA;
            end
            ESA_IGNORE: begin
               state <= ESA_IGNORE;
            end
         endcase
      end
   end

   // drive ack from first scl fall after the eighth bit to the next fall
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sda_oe <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe <= 1'b0;
      end else if (scl_fall) begin
         sda_oe <= state == ESA_ACK && ack_pend; // see R6 see R7
      end
   end
   assign sda_out = 1'b0; // see R8

   assign word_addr = {addr_hi, shreg};

   // command decode after the second address byte
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cmd_out <= '0;
      end else if (start_det) begin
         cmd_out <= '0;
      end else if (scl_rise && state == ESA_ACK && !after_sel && !addr_phase) begin
         cmd_out.valid <= 1'b1;
         // type kept from the select byte, the shift register now holds the address
         cmd_out.idpage <= sel_was_id;
         cmd_out.addr <= word_addr[WA_MEM_BITS-1:0];
         cmd_out.wr_allowed <= cfg_unlocked || !wp_sync[1]; // see R15 see R16
         if (word_addr[15:13] == WA_MEM) begin
            cmd_out.cmd <= CMD_MEM; // see R18
         end else if (!cfg_unlocked) begin
            cmd_out.cmd <= word_addr[15:12] == WA_UNLOCK ? CMD_UNLOCK : CMD_NONE; // see R19
         end else if (word_addr[15:12] == WA_DEVREG) begin
            cmd_out.cmd <= CMD_DEVREG;
         end else if (word_addr[15:12] == WA_LOCK) begin
            cmd_out.cmd <= CMD_LOCK;
         end else if (word_addr[15:12] == WA_LOCK_DEF) begin
            cmd_out.cmd <= CMD_LOCK_DEF;
         end else if (word_addr[15:12] == WA_IDEXT) begin
            cmd_out.cmd <= CMD_IDEXT;
            cmd_out.addr <= {8'h00, word_addr[WA_IDEXT_BITS-1:0]};
         end else begin
            cmd_out.cmd <= CMD_NONE;
         end
      end
   end

   // device register; unlock and lock act on the decoded command
   always_ff @(posedge clk) begin
      if (!nrst) begin
         configurable_address_code <= CFG_ADDR_RESET; // see R17
         cfg_unlocked <= CFG_UNLOCKED_RESET;
      end else begin
         if (cmd_out.valid && stop_det) begin
            if (cmd_out.cmd == CMD_UNLOCK) begin
               cfg_unlocked <= 1'b1;
            end else if (cmd_out.cmd == CMD_LOCK) begin
               cfg_unlocked <= 1'b0;
            end else if (cmd_out.cmd == CMD_LOCK_DEF) begin
               cfg_unlocked <= 1'b0;
               configurable_address_code <= CFG_ADDR_RESET;
            end
         end
         if (cfg_we && cfg_unlocked) begin
            configurable_address_code <= cfg_wdata;
         end
      end
   end

   // standby: idle bus and no internal write running
   always_ff @(posedge clk) begin
      if (!nrst) begin
         standby <= 1'b1;
      end else begin
         standby <= state == ESA_IDLE && !write_busy && !start_det; // see R11
      end
   end

   // helper: counts scl rises within the selected byte
   always_ff @(posedge clk) begin
      if (!nrst || start_det) begin
         ack_cnt <= 3'h0;
      end else if (scl_rise && state == ESA_SEL) begin
         ack_cnt <= ack_cnt + 3'h1;
      end
   end

   sequence s_sel_done;
      scl_rise && state == ESA_SEL && bit_cnt == 3'h7 && sel_match && !write_busy
         && !start_det && !stop_det;
   endsequence

   chk_start_restart: assert property (@(posedge clk) disable iff (!nrst) // see R1
      start_det |=> state == ESA_SEL && bit_cnt == 3'h0)
      else $error("start did not restart select");
   chk_stop_idle: assert property (@(posedge clk) disable iff (!nrst) // see R2
      stop_det && !start_det |=> state == ESA_IDLE)
      else $error("stop did not return to idle");
   chk_never_high: assert property (@(posedge clk) disable iff (!nrst) // see R8
      sda_out == 1'b0)
      else $error("sda driven high");
   chk_sel_ack: assert property (@(posedge clk) disable iff (!nrst) // see R7
      s_sel_done |=> state == ESA_ACK && ack_pend)
      else $error("matching select not acknowledged");
   chk_oe_in_ack: assert property (@(posedge clk) disable iff (!nrst) // see R6
      $rose(sda_oe) |-> $past(state) == ESA_ACK)
      else $error("sda pulled low outside ack");
   chk_bad_type: assert property (@(posedge clk) disable iff (!nrst) // see R12
      scl_rise && state == ESA_SEL && bit_cnt == 3'h7 && !cfg_unlocked
         && sel_type != TYPE_MAIN && sel_type != TYPE_IDPAGE && !start_det && !stop_det
         |=> state == ESA_IGNORE)
      else $error("wrong type acknowledged");
   chk_rw_bit: assert property (@(posedge clk) disable iff (!nrst) // see R14
      s_sel_done |=> sel_read == $past(sda_sync[1]))
      else $error("read bit mis-captured");
   chk_locked_cmds: assert property (@(posedge clk) disable iff (!nrst) // see R19
      $rose(cmd_out.valid) && !$past(cfg_unlocked)
         |-> cmd_out.cmd inside {CMD_NONE, CMD_MEM, CMD_UNLOCK})
      else $error("command decoded while locked");
   chk_standby_busy: assert property (@(posedge clk) disable iff (!nrst) // see R11
      write_busy |=> !standby)
      else $error("standby during internal write");

   sequence s_addr_done;
      scl_rise && state == ESA_ACK && !after_sel && !addr_phase && !start_det && !stop_det;
   endsequence

   chk_bit_count: assert property (@(posedge clk) disable iff (!nrst) // see R4
      state == ESA_SEL |-> ack_cnt == bit_cnt)
      else $error("select bits and scl pulses disagree");
   chk_ack_release: assert property (@(posedge clk) disable iff (!nrst) // see R7
      sda_oe && scl_fall && !start_det && !stop_det |=> !sda_oe)
      else $error("ack held past the ninth clock");
   chk_ignore_quiet: assert property (@(posedge clk) disable iff (!nrst) // see R12
      state == ESA_IGNORE |-> !sda_oe)
      else $error("sda pulled while ignoring the bus");
   chk_idle_hold: assert property (@(posedge clk) disable iff (!nrst) // see R1
      state == ESA_IDLE && !start_det |=> state == ESA_IDLE)
      else $error("left idle without a start");
   chk_sel_refused: assert property (@(posedge clk) disable iff (!nrst) // see R13
      scl_rise && state == ESA_SEL && bit_cnt == 3'h7 && !cfg_unlocked
         && next_shreg[SEL_TYPE_POS-1:SEL_PINS_POS] != pins && !start_det && !stop_det
         |=> state == ESA_IGNORE)
      else $error("select with wrong pins acknowledged");
   chk_mem_pairing: assert property (@(posedge clk) disable iff (!nrst) // see R20
      s_addr_done && addr_hi[7:5] == WA_MEM |=> cmd_out.cmd == CMD_MEM
         && cmd_out.addr[7:0] == $past(shreg) && cmd_out.addr[12:8] == $past(addr_hi[4:0]))
      else $error("word address bytes mis-paired");
   chk_wp_blocks: assert property (@(posedge clk) disable iff (!nrst) // see R15
      $rose(cmd_out.valid) && !$past(cfg_unlocked) && $past(wp_sync[1])
         |-> !cmd_out.wr_allowed)
      else $error("write allowed under write protect");
   chk_code_locked: assert property (@(posedge clk) disable iff (!nrst) // see R16
      !cfg_unlocked && !(cmd_out.valid && stop_det) |=> $stable(configurable_address_code))
      else $error("address code changed while locked");
endmodule

/* inc/esa_pkg.sv */
// shared constants and types for the two-wire eeprom slave front end
package esa_pkg;
   localparam logic [3:0] TYPE_MAIN = 4'ha;
   localparam logic [3:0] TYPE_IDPAGE = 4'hb;
   localparam logic [6:0] CFG_ADDR_RESET = 7'h50;
   localparam logic CFG_UNLOCKED_RESET = 1'b0;
   localparam int SEL_TYPE_POS = 4;
   localparam int SEL_PINS_POS = 1;
   localparam int SEL_RW_POS = 0;
   localparam int BIT_LAST = 7;
   localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
   localparam logic [2:0] WA_MEM = 3'h0;
   localparam logic [3:0] WA_DEVREG = 4'he;
   localparam logic [3:0] WA_LOCK = 4'ha;
   localparam logic [3:0] WA_LOCK_DEF = 4'hb;
   localparam logic [3:0] WA_UNLOCK = 4'hc;
   localparam logic [3:0] WA_IDEXT = 4'h8;
   localparam int WA_MEM_BITS = 13;
   localparam int WA_IDEXT_BITS = 5;

   typedef enum logic [5:0] {
      ESA_IDLE = 6'h01,
      ESA_SEL = 6'h02,
      ESA_ACK = 6'h04,
      ESA_ADDR = 6'h08,
      ESA_DATA = 6'h10,
      ESA_IGNORE = 6'h20
   } esa_state_e;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_MEM = 3'h1,
      CMD_DEVREG = 3'h2,
      CMD_LOCK = 3'h3,
      CMD_LOCK_DEF = 3'h4,
      CMD_UNLOCK = 3'h5,
      CMD_IDEXT = 3'h6
   } esa_cmd_e;

   typedef struct packed {
      logic valid;
      esa_cmd_e cmd;
      logic idpage;
      logic [12:0] addr;
      logic wr_allowed;
   } esa_cmd_s;
endpackage

/* verif/esa_master.sv */
// two-wire bus master model: drives the clock and pulls data low
`timescale 1ns/1ps
module esa_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic drop_clk();
      wait_clk(2);
      scl = 1'b0;
   endtask
   // data moves only with scl low, one bit per pulse
   task automatic bit_x(input logic b, output logic r);
      wait_clk(2);
      sda_pull = !b;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(4);
      r = sda;
      scl = 1'b0;
   endtask
   // data falls under scl high; begun only from a released bus
   task automatic start();
      wait_clk(2);
      sda_pull = 1'b0;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(4);
      sda_pull = 1'b1;
      wait_clk(4);
      scl = 1'b0;
   endtask
   // data rises under scl high, bus left idle
   task automatic stop();
      wait_clk(2);
      sda_pull = 1'b1;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(4);
      sda_pull = 1'b0;
      wait_clk(4);
   endtask
   // ninth bit released so the pull-up shows a missing ack
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], r);
      end
      bit_x(1'b1, r);
      ack = !r;
   endtask
   // nine released pulses, then a start to reset the slave
   task automatic recover();
      logic r;
      for (int i = 0; i < 9; i++) begin
         bit_x(1'b1, r);
      end
      wait_clk(4);
      start();
   endtask
endmodule

/* verif/test_esa_slave.sv */
// self-checking bench for the two-wire slave front end
`timescale 1ns/1ps
module test_esa_slave;
   import esa_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, m_pull, sda_out, sda_oe, wp = 1'b0, busy = 1'b0, cfg_we = 1'b0;
   logic [2:0] pins = 3'h0;
   logic [6:0] cfg_wdata = 7'h00;
   logic [6:0] code;
   logic unlocked, standby, sel_read;
   esa_cmd_s cmd;
   int mismatches = 0;
   int n_tests = 0;
   // open drain: released line reads high through the pull-up
   wire sda_w = (sda_oe ? sda_out : 1'b1) & !m_pull;
   always #2 clk = ~clk;
   esa_master u_m (.clk(clk), .sda(sda_w), .scl(scl), .sda_pull(m_pull));
   esa_slave dut_u (.clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .chip_select_pin_low(pins[0]), .chip_select_pin_mid(pins[1]),
      .chip_select_pin_high(pins[2]), .write_protect(wp), .write_busy(busy),
      .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .configurable_address_code(code),
      .cfg_unlocked(unlocked), .standby(standby), .cmd_out(cmd), .sel_read(sel_read));
   task automatic finish_test();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic op(input logic [7:0] sel, hi, lo, input logic exp_ack);
      logic a;
      u_m.start();
      u_m.send_byte(sel, a);
      chk(a, exp_ack);
      if (a === 1'b1 && sel[0] === 1'b0) begin
         u_m.send_byte(hi, a);
         chk(a, 1'b1);
         u_m.send_byte(lo, a);
         chk(a, 1'b1);
      end
      u_m.stop();
      repeat (4) @(negedge clk);
   endtask
   task automatic t_reset();
      chk(standby, 1'b1);
      chk(code, 7'h50);
      chk(unlocked, 1'b0);
      chk(cmd, '0);
      chk(sda_oe, 1'b0);
   endtask
   task automatic t_nostart();
      logic a;
      u_m.drop_clk();
      u_m.send_byte(8'ha0, a);
      chk(a, 1'b0);
      u_m.stop();
   endtask
   task automatic t_select();
      logic [3:0] types [4] = '{4'ha, 4'hb, 4'h9, 4'he};
      pins = 3'h5;
      foreach (types[i]) begin
         op({types[i], 3'h5, 1'b0}, 8'h1f, 8'h34, types[i] inside {4'ha, 4'hb});
         if (types[i] inside {4'ha, 4'hb}) begin
            chk(cmd.valid, 1'b1);
            chk(cmd.cmd, CMD_MEM);
            chk(cmd.addr, 13'h1f34);
            chk(cmd.idpage, types[i] == 4'hb);
         end
      end
      op(8'ha8, 8'h00, 8'h00, 1'b0);
      op(8'hab, 8'h00, 8'h00, 1'b1);
      chk(sel_read, 1'b1);
      chk(standby, 1'b1);
      chk(sda_out, 1'b0);
      wp = 1'b1;
      op(8'haa, 8'h00, 8'h10, 1'b1);
      chk(cmd.wr_allowed, 1'b0);
      wp = 1'b0;
      op(8'haa, 8'h00, 8'h10, 1'b1);
      chk(cmd.wr_allowed, 1'b1);
      chk(sel_read, 1'b0);
   endtask
   task automatic t_commands();
      op(8'haa, 8'he0, 8'h00, 1'b1);
      chk(cmd.cmd, CMD_NONE);
      op(8'haa, 8'hc0, 8'h00, 1'b1);
      chk(cmd.cmd, CMD_UNLOCK);
      chk(unlocked, 1'b1);
      cfg_wdata = 7'h23;
      cfg_we = 1'b1;
      @(negedge clk);
      cfg_we = 1'b0;
      @(negedge clk);
      chk(code, 7'h23);
      wp = 1'b1;
      pins = 3'h0;
      op(8'haa, 8'h00, 8'h00, 1'b0);
      op(8'h46, 8'h00, 8'h05, 1'b1);
      chk(cmd.wr_allowed, 1'b1);
      op(8'h46, 8'he0, 8'h00, 1'b1);
      chk(cmd.cmd, CMD_DEVREG);
      op(8'h46, 8'h80, 8'h05, 1'b1);
      chk(cmd.cmd, CMD_IDEXT);
      chk(cmd.addr, 13'h0005);
      op(8'h46, 8'ha0, 8'h00, 1'b1);
      chk(cmd.cmd, CMD_LOCK);
      chk(unlocked, 1'b0);
      chk(code, 7'h23);
      op(8'ha0, 8'hc0, 8'h00, 1'b1);
      chk(unlocked, 1'b1);
      op(8'h46, 8'hb0, 8'h00, 1'b1);
      chk(cmd.cmd, CMD_LOCK_DEF);
      chk(unlocked, 1'b0);
      chk(code, 7'h50);
      wp = 1'b0;
   endtask
   task automatic t_busy_recover();
      logic a;
      busy = 1'b1;
      op(8'ha0, 8'h00, 8'h00, 1'b0);
      chk(standby, 1'b0);
      busy = 1'b0;
      u_m.start();
      u_m.send_byte(8'ha0, a);
      u_m.recover();
      u_m.send_byte(8'ha0, a);
      chk(a, 1'b1);
      u_m.send_byte(8'h02, a);
      u_m.send_byte(8'h99, a);
      u_m.stop();
      chk(cmd.addr, 13'h0299);
   endtask
   initial begin
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      t_reset();
      t_nostart();
      t_select();
      t_commands();
      t_busy_recover();
      finish_test();
   end
   // watchdog sized well past the ~20 bus operations above
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      finish_test();
   end
endmodule
